/* File: pps_pkg.sv */
// Constants, register map and types of the profile position sequencer.
// Behaviour
// - Positioning behaviour applies only while operating mode select equals one.
// - A new travel command starts only on a rising edge of control bit 4.
// - Entering this mode with bit 4 already high counts as a start.
// - Bit 5 high replaces the running command; low lets it finish first.
// - Bit 6 selects absolute or relative target; option bits 0-1 pick base.
// - Bit 8 halts with halt-option deceleration; release re-accelerates with start ramp.
// - Bits 5 low, 9 high: pass through target at profile speed, then continue.
// - Bits 5 and 9 low: finish current positioning before the next target.
// - Bit 9 is ignored when ramp speed cannot be met at the target.
// - Status bit 10 set after target reached and inside window for dwell time.
// - Status bit 11 high while demand position lies outside software limits.
// - Status bit 12 acknowledges a valid set point, following control bit 4.
// - Queued command: acknowledge clears when buffer free; commands during acknowledge dropped.
// - Acknowledge withheld for unreachable target or when a target already pends.
// - Status bit 13 set in closed loop when following error exceeds window too long.
// - Host writes target, raises bit 4; device acknowledges, moves, reports reached.
// - Device may clear control bit 4 itself, governed by option bits 4 and 5.
// - One further command with own parameters is buffered; more are dropped.
// - With bit 5 set the buffer is bypassed and commands apply directly.
// - Actual position sampled per tick; sample at target is next relative base.
// - Inputs and objects are processed on a fixed 1 ms tick.
// - Absolute targets clamped to software limits; outside only inward moves accepted.
package pps_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [15:0] PPS_ADDR_CTRL = 16'h6040;
   localparam logic [15:0] PPS_ADDR_STAT = 16'h6041;
   localparam logic [7:0] PPS_MODE_PROFILE_POS = 8'h01;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int PPS_CW_NEW_SP = 4;
   localparam int PPS_CW_IMMEDIATE = 5;
   localparam int PPS_CW_RELATIVE = 6;
   localparam int PPS_CW_HALT = 8;
   localparam int PPS_CW_CHANGE_ON_SP = 9;
   localparam int PPS_SW_REACHED = 10;
   localparam int PPS_SW_LIMIT = 11;
   localparam int PPS_SW_ACK = 12;
   localparam int PPS_SW_FOLLOW_ERR = 13;
   localparam int PPS_OPT_REL_LO = 0;
   localparam int PPS_OPT_REL_HI = 1;
   localparam int PPS_OPT_AUTOCLR_LO = 4;
   localparam int PPS_OPT_AUTOCLR_HI = 5;

   // Relative base selection in the option object.
   localparam logic [1:0] PPS_REL_LAST_TARGET = 2'h0;
   localparam logic [1:0] PPS_REL_DEMAND = 2'h1;
   localparam logic [1:0] PPS_REL_ACTUAL = 2'h2;

   // Automatic clearing selection in the option object.
   localparam logic [1:0] PPS_AUTOCLR_NONE = 2'h0;
   localparam logic [1:0] PPS_AUTOCLR_AT_ACK = 2'h1;
   localparam logic [1:0] PPS_AUTOCLR_AT_DONE = 2'h2;

   localparam logic [15:0] PPS_CTRL_RESET = 16'h0000;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int PPS_CLK_HZ = 100_000_000;
   localparam int PPS_TICK_US = 1000;
   localparam int PPS_TICK_CYCLES = PPS_CLK_HZ / 1_000_000 * PPS_TICK_US;

   typedef enum logic [1:0] {
      PPS_IDLE,
      PPS_MOVE,
      PPS_HALTED
   } pps_state_e;

endpackage : pps_pkg

/* File: pps_window_timer.sv */
// Dwell timer: counts ticks a condition holds and flags when it reaches a limit.
module pps_window_timer
   import pps_pkg::*;
#(
   parameter int CW = 16
)
(
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_tick,
   input wire logic i_cond,
   input wire logic [CW-1:0] i_limit,
   output logic o_expired
);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic hit;

   assign hit = (cnt_q >= i_limit);
   assign cnt_d = !i_cond ? '0 : (i_tick && !hit) ? cnt_q + 1'b1 : cnt_q;
   assign o_expired = i_cond && hit;

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_resetn)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

endmodule : pps_window_timer

/* File: pps_sequencer.sv */
// Profile position sequencer: set-point handshake, command buffer and status word.
module pps_sequencer
   import pps_pkg::*;
#(
   parameter int PW = 32,
   parameter int TW = 16,
   parameter int TICK_CYCLES = PPS_TICK_CYCLES
)
(
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_ctrl_we,
   input wire logic [15:0] i_ctrl_wdata,
   output logic [15:0] o_ctrl_word,
   output logic [15:0] o_status_word,
   input wire logic [7:0] i_operating_mode_select,
   input wire logic [PW-1:0] i_target_pos,
   input wire logic [PW-1:0] i_profile_vel,
   input wire logic [PW-1:0] i_profile_acc,
   input wire logic [PW-1:0] i_profile_dec,
   input wire logic [7:0] i_pos_option,
   input wire logic [PW-1:0] i_limit_min,
   input wire logic [PW-1:0] i_limit_max,
   input wire logic [PW-1:0] i_window,
   input wire logic [TW-1:0] i_window_time,
   input wire logic [PW-1:0] i_ferr_window,
   input wire logic [TW-1:0] i_ferr_time,
   input wire logic i_closed_loop,
   input wire logic [PW-1:0] i_actual_pos,
   input wire logic [PW-1:0] i_demand_pos,
   input wire logic i_ramp_at_target,
   input wire logic i_ramp_speed_ok,
   input wire logic i_reachable,
   output logic o_cmd_valid,
   output logic [PW-1:0] o_cmd_target,
   output logic [PW-1:0] o_cmd_vel,
   output logic [PW-1:0] o_cmd_acc,
   output logic [PW-1:0] o_cmd_dec,
   output logic o_cmd_pass_through,
   output logic o_halt,
   output logic o_halt_release
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [PW-1:0] pps_abs_diff(input logic [PW-1:0] a, input logic [PW-1:0] b);
      logic signed [PW:0] d;
      d = $signed({a[PW-1], a}) - $signed({b[PW-1], b});
      pps_abs_diff = d[PW] ? PW'(-d) : d[PW-1:0];
   endfunction : pps_abs_diff

   function automatic logic pps_outside(input logic [PW-1:0] p, input logic [PW-1:0] lo,
                                        input logic [PW-1:0] hi);
      pps_outside = ($signed(p) < $signed(lo)) || ($signed(p) > $signed(hi));
   endfunction : pps_outside

   function automatic logic [PW-1:0] pps_clamp(input logic [PW-1:0] p, input logic [PW-1:0] lo,
                                               input logic [PW-1:0] hi);
      if ($signed(p) < $signed(lo))
         pps_clamp = lo;
      else if ($signed(p) > $signed(hi))
         pps_clamp = hi;
      else
         pps_clamp = p;
   endfunction : pps_clamp

   // ----------------------------------------
   // Application tick
   // ----------------------------------------
   localparam int TCW = $clog2(TICK_CYCLES + 1);
   logic [TCW-1:0] tick_cnt_q;
   logic tick;

   assign tick = (tick_cnt_q == TCW'(TICK_CYCLES - 1));

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_resetn)
         tick_cnt_q <= '0;
      else
         tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
   end

   // ----------------------------------------
   // Control word and sampled inputs
   // ----------------------------------------
   logic [15:0] ctrl_q;
   logic [15:0] ctrl_d;
   logic new_sp_prev_q;
   logic halt_prev_q;
   logic mode_prev_q;
   logic [PW-1:0] actual_q;
   logic [PW-1:0] last_target_q;
   logic auto_clear;

   wire mode_on = (i_operating_mode_select == PPS_MODE_PROFILE_POS);
   wire mode_on_t = mode_on;
   wire new_sp = ctrl_q[PPS_CW_NEW_SP] && mode_on_t;
   wire imm = ctrl_q[PPS_CW_IMMEDIATE];
   wire rel = ctrl_q[PPS_CW_RELATIVE];
   wire halt = ctrl_q[PPS_CW_HALT] && mode_on_t;
   wire chg_sp = ctrl_q[PPS_CW_CHANGE_ON_SP];
   wire [1:0] rel_sel = i_pos_option[PPS_OPT_REL_HI:PPS_OPT_REL_LO];
   wire [1:0] autoclr_sel = i_pos_option[PPS_OPT_AUTOCLR_HI:PPS_OPT_AUTOCLR_LO];

   // Entering the mode with the bit high reads as a fresh edge, since the previous
   // sample is forced low while the mode is off.
   wire start_edge = tick && new_sp && !new_sp_prev_q;

   assign ctrl_d = i_ctrl_we ? i_ctrl_wdata :
                   auto_clear ? (ctrl_q & ~(16'h0001 << PPS_CW_NEW_SP)) : ctrl_q;

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_resetn)
      begin
         ctrl_q <= PPS_CTRL_RESET;
         new_sp_prev_q <= 1'b0;
         halt_prev_q <= 1'b0;
         mode_prev_q <= 1'b0;
         actual_q <= '0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         if (tick)
         begin
            new_sp_prev_q <= new_sp;
            halt_prev_q <= halt;
            mode_prev_q <= mode_on;
            actual_q <= i_actual_pos;
         end
      end
   end

   // ----------------------------------------
   // Target computation
   // ----------------------------------------
   wire [PW-1:0] rel_base = (rel_sel == PPS_REL_DEMAND) ? i_demand_pos :
                            (rel_sel == PPS_REL_ACTUAL) ? actual_q : last_target_q;
   wire [PW-1:0] raw_target = rel ? rel_base + i_target_pos : i_target_pos;
   wire [PW-1:0] new_target = pps_clamp(raw_target, i_limit_min, i_limit_max);
   wire act_out = pps_outside(actual_q, i_limit_min, i_limit_max);
   // When already outside the range, only a move toward it passes.
   wire inward = !act_out ||
                 ($signed(actual_q) < $signed(i_limit_min) && $signed(raw_target) > $signed(actual_q)) ||
                 ($signed(actual_q) > $signed(i_limit_max) && $signed(raw_target) < $signed(actual_q));
   wire sp_valid = i_reachable && inward;

   // ----------------------------------------
   // Sequencer with single-entry buffer
   // ----------------------------------------
   pps_state_e state_q;
   pps_state_e state_d;
   logic ack_q;
   logic buf_full_q;
   logic [PW-1:0] buf_target_q;
   logic [PW-1:0] buf_vel_q;
   logic [PW-1:0] buf_acc_q;
   logic [PW-1:0] buf_dec_q;
   logic buf_pass_q;
   logic reached_flag_q;

   wire moving = (state_q != PPS_IDLE);
   wire buf_full_in = buf_full_q;
   // A command while acknowledge is high or the buffer is full is dropped.
   wire take = start_edge && sp_valid && !ack_q;
   wire take_direct = take && (!moving || imm);
   wire take_buf = take && moving && !imm && !buf_full_in;
   wire pass_ok = chg_sp && i_ramp_speed_ok;
   wire arrive = tick && (state_q == PPS_MOVE) && i_ramp_at_target;
   wire pop = arrive && buf_full_q;

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         PPS_IDLE:
            if (take_direct)
               state_d = PPS_MOVE;
         PPS_MOVE:
            if (tick && halt && !halt_prev_q)
               state_d = PPS_HALTED;
            else if (arrive && !buf_full_q && !take_direct)
               state_d = PPS_IDLE;
         PPS_HALTED:
            if (tick && !halt && halt_prev_q)
               state_d = PPS_MOVE;
         default:
            state_d = PPS_IDLE;
      endcase
      if (!mode_on)
         state_d = PPS_IDLE;
   end

   // Acknowledge follows bit 4 when applied directly; a buffered command holds it
   // until bit 4 is low and the buffer can take another one.
   wire ack_set = take_direct || take_buf;
   wire ack_clr = tick && !new_sp && !(buf_full_q && !pop);

   assign auto_clear = tick && ack_q &&
                       ((autoclr_sel == PPS_AUTOCLR_AT_ACK) ||
                        (autoclr_sel == PPS_AUTOCLR_AT_DONE && state_q == PPS_IDLE));

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_resetn)
      begin
         state_q <= PPS_IDLE;
         ack_q <= 1'b0;
         buf_full_q <= 1'b0;
         reached_flag_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         ack_q <= mode_on && (ack_set || (ack_q && !ack_clr));
         buf_full_q <= mode_on && (take_buf || (buf_full_q && !pop && !take_direct));
         if (ack_set)
            reached_flag_q <= 1'b0;
         else if (arrive && !buf_full_q)
            reached_flag_q <= 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_resetn)
      begin
         buf_target_q <= '0;
         buf_vel_q <= '0;
         buf_acc_q <= '0;
         buf_dec_q <= '0;
         buf_pass_q <= 1'b0;
         o_cmd_target <= '0;
         o_cmd_vel <= '0;
         o_cmd_acc <= '0;
         o_cmd_dec <= '0;
         o_cmd_pass_through <= 1'b0;
         o_cmd_valid <= 1'b0;
         last_target_q <= '0;
      end
      else
      begin
         o_cmd_valid <= 1'b0;
         if (take_buf)
         begin
            buf_target_q <= new_target;
            buf_vel_q <= i_profile_vel;
            buf_acc_q <= i_profile_acc;
            buf_dec_q <= i_profile_dec;
            buf_pass_q <= !imm && pass_ok;
            last_target_q <= new_target;
            o_cmd_pass_through <= pass_ok;
         end
         if (take_direct)
         begin
            o_cmd_target <= new_target;
            o_cmd_vel <= i_profile_vel;
            o_cmd_acc <= i_profile_acc;
            o_cmd_dec <= i_profile_dec;
            o_cmd_pass_through <= 1'b0;
            o_cmd_valid <= 1'b1;
            last_target_q <= new_target;
         end
         else if (pop)
         begin
            o_cmd_target <= buf_target_q;
            o_cmd_vel <= buf_vel_q;
            o_cmd_acc <= buf_acc_q;
            o_cmd_dec <= buf_dec_q;
            o_cmd_pass_through <= 1'b0;
            o_cmd_valid <= 1'b1;
            last_target_q <= buf_pass_q ? buf_target_q : actual_q;
         end
      end
   end

   // ----------------------------------------
   // Windows and status word
   // ----------------------------------------
   logic in_window;
   logic ferr_over;
   logic settled;
   logic ferr_expired;
   logic [15:0] status_d;

   assign in_window = reached_flag_q && (pps_abs_diff(actual_q, last_target_q) <= i_window);
   assign ferr_over = i_closed_loop && (pps_abs_diff(i_demand_pos, actual_q) > i_ferr_window);

   pps_window_timer #(.CW(TW)) u_reach_timer (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_tick(tick),
      .i_cond(in_window),
      .i_limit(i_window_time),
      .o_expired(settled)
   );

   pps_window_timer #(.CW(TW)) u_ferr_timer (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_tick(tick),
      .i_cond(ferr_over),
      .i_limit(i_ferr_time),
      .o_expired(ferr_expired)
   );

   always_comb
   begin
      status_d = '0;
      if (mode_on)
      begin
         status_d[PPS_SW_REACHED] = settled;
         status_d[PPS_SW_LIMIT] = pps_outside(i_demand_pos, i_limit_min, i_limit_max);
         status_d[PPS_SW_ACK] = ack_q;
         status_d[PPS_SW_FOLLOW_ERR] = ferr_expired;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_resetn)
      begin
         o_status_word <= '0;
         o_halt <= 1'b0;
         o_halt_release <= 1'b0;
      end
      else
      begin
         o_status_word <= status_d;
         o_halt <= (state_d == PPS_HALTED);
         o_halt_release <= (state_q == PPS_HALTED) && (state_d == PPS_MOVE);
      end
   end

   assign o_ctrl_word = ctrl_q;

endmodule : pps_sequencer

/* File: pps_sequencer_checker.sv */
// Checker: port-level properties of the profile position sequencer.
module pps_sequencer_checker
   import pps_pkg::*;
#(
   parameter int PW = 32,
   parameter int TICK_CYCLES = PPS_TICK_CYCLES
)
(
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_ctrl_we,
   input wire logic [15:0] i_ctrl_wdata,
   input wire logic [15:0] o_ctrl_word,
   input wire logic [15:0] o_status_word,
   input wire logic [7:0] i_operating_mode_select,
   input wire logic [PW-1:0] i_demand_pos,
   input wire logic [PW-1:0] i_limit_min,
   input wire logic [PW-1:0] i_limit_max,
   input wire logic o_cmd_valid,
   input wire logic [PW-1:0] o_cmd_target,
   input wire logic o_halt,
   input wire logic o_halt_release
);
   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_resetn);
   wire logic outside;
   assign outside = ($signed(i_demand_pos) < $signed(i_limit_min)) ||
      ($signed(i_demand_pos) > $signed(i_limit_max));
   sequence s_mode_out;
      (i_operating_mode_select != PPS_MODE_PROFILE_POS) [*3];
   endsequence
   sequence s_steady_in_mode;
      (i_operating_mode_select == PPS_MODE_PROFILE_POS) && $stable(i_operating_mode_select)
         && $stable(i_demand_pos) && $stable(i_limit_min) && $stable(i_limit_max);
   endsequence
   a_cmd_single_pulse: assert property (o_cmd_valid |=> !o_cmd_valid)
      else $error("command strobe longer than one cycle");
   a_status_reserved: assert property ((o_status_word & 16'hc3ff) == 16'h0000)
      else $error("reserved status bit set");
   a_mode_gate: assert property (s_mode_out |-> !o_cmd_valid && o_status_word[13:10] == 4'h0)
      else $error("positioning activity outside positioning mode");
   a_ack_in_mode: assert property ($rose(o_status_word[PPS_SW_ACK]) |->
      $past(i_operating_mode_select, 2) == PPS_MODE_PROFILE_POS)
      else $error("acknowledge raised outside positioning mode");
   a_ctrl_write: assert property (i_ctrl_we |=>
      (o_ctrl_word & 16'hffef) == ($past(i_ctrl_wdata) & 16'hffef))
      else $error("control word not taken from write");
   a_halt_cause: assert property ($rose(o_halt) |->
      ($past(o_ctrl_word[PPS_CW_HALT]) || $past(o_ctrl_word[PPS_CW_HALT], 2)))
      else $error("halt without halt bit");
   a_release_pulse: assert property (o_halt_release |=> !o_halt_release && !o_halt)
      else $error("release strobe malformed");
   a_target_moves: assert property ($changed(o_cmd_target) |-> o_cmd_valid)
      else $error("command target changed without strobe");
   a_limit_flag: assert property (s_steady_in_mode |->
      o_status_word[PPS_SW_LIMIT] == outside)
      else $error("limit flag disagrees with demand position");
endmodule : pps_sequencer_checker

bind pps_sequencer pps_sequencer_checker #(.PW(PW), .TICK_CYCLES(TICK_CYCLES)) u_chk (
   .i_clk_sys, .i_resetn, .i_ctrl_we, .i_ctrl_wdata, .o_ctrl_word, .o_status_word,
   .i_operating_mode_select, .i_demand_pos, .i_limit_min, .i_limit_max, .o_cmd_valid,
   .o_cmd_target, .o_halt, .o_halt_release
);

/* File: pps_host_model.sv */
// Host model: writes the control word the way a fieldbus master does.
module pps_host_model
   import pps_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic [15:0] i_status,
   output logic o_we,
   output logic [15:0] o_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // -------------
   // Host requests
   // -------------
   initial
   begin
      o_we = 1'b0;
      o_wdata = 16'h0000;
   end
   task automatic put(input logic [15:0] w);
      @(posedge i_clk_sys);
      o_we <= 1'b1;
      o_wdata <= w;
      @(posedge i_clk_sys);
      o_we <= 1'b0;
      o_wdata <= ~w; // Idle data bus must never echo the last word.
   endtask : put
   // Bit 4 is shown low on a tick before it rises again.
   task automatic setpoint(input logic [15:0] w);
      int n;
      n = 0;
      put(w & 16'hffef);
      while (i_status[PPS_SW_ACK] === 1'b1 && n < 50)
      begin
         @(posedge i_clk_sys);
         n++;
      end
      repeat (12) @(posedge i_clk_sys);
      put(w | 16'h0010);
   endtask : setpoint
endmodule : pps_host_model

/* File: tb.sv */
// Testbench: host model drives the sequencer through its set-point scenarios.
module tb;
   import pps_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // -------
   // Signals
   // -------
   logic i_clk_sys = 1'b0;
   logic i_resetn = 1'b0;
   logic i_closed_loop = 1'b0;
   logic i_ramp_at_target = 1'b0;
   logic i_ramp_speed_ok = 1'b1;
   logic i_reachable = 1'b1;
   logic [7:0] i_operating_mode_select = 8'h01;
   logic [7:0] i_pos_option = 8'h00;
   logic [15:0] i_window_time = 16'h0002;
   logic [15:0] i_ferr_time = 16'h0002;
   logic [31:0] i_target_pos = 32'h0000_0000;
   logic [31:0] i_profile_vel = 32'h0000_01f4;
   logic [31:0] i_profile_acc = 32'h0000_01f4;
   logic [31:0] i_profile_dec = 32'h0000_01f4;
   logic [31:0] i_limit_min = 32'hffff_fc18;
   logic [31:0] i_limit_max = 32'h0000_03e8;
   logic [31:0] i_window = 32'h0000_000a;
   logic [31:0] i_ferr_window = 32'h0000_0005;
   logic [31:0] i_actual_pos = 32'h0000_0000;
   logic [31:0] i_demand_pos = 32'h0000_0000;
   logic i_ctrl_we, o_cmd_valid, o_cmd_pass_through, o_halt, o_halt_release;
   logic [15:0] i_ctrl_wdata, o_ctrl_word, o_status_word;
   logic [31:0] o_cmd_target, o_cmd_vel, o_cmd_acc, o_cmd_dec;
   logic [31:0] last_tgt = 32'h0000_0000;
   logic [16:0] obs;
   int n_fail = 0;
   int total_checks = 0;
   int n_cmd = 0;
   int n_rel = 0;
   int cycles = 0;
   assign obs = {o_halt, o_status_word};
   always #5 i_clk_sys = ~i_clk_sys;
   pps_host_model u_host (.i_clk_sys, .i_status(o_status_word), .o_we(i_ctrl_we),
      .o_wdata(i_ctrl_wdata));
   pps_sequencer #(.TICK_CYCLES(10)) u_dut (.i_clk_sys, .i_resetn, .i_ctrl_we, .i_ctrl_wdata,
      .o_ctrl_word, .o_status_word, .i_operating_mode_select, .i_target_pos, .i_profile_vel,
      .i_profile_acc, .i_profile_dec, .i_pos_option,
      .i_limit_min, .i_limit_max, .i_window, .i_window_time, .i_ferr_window, .i_ferr_time,
      .i_closed_loop, .i_actual_pos, .i_demand_pos, .i_ramp_at_target, .i_ramp_speed_ok,
      .i_reachable, .o_cmd_valid, .o_cmd_target, .o_cmd_vel, .o_cmd_acc, .o_cmd_dec,
      .o_cmd_pass_through, .o_halt, .o_halt_release);
   always @(posedge i_clk_sys)
   begin
      cycles <= cycles + 1;
      if (o_cmd_valid === 1'b1)
      begin
         n_cmd <= n_cmd + 1;
         last_tgt <= o_cmd_target;
      end
      if (o_halt_release === 1'b1)
         n_rel <= n_rel + 1;
   end
   // The whole run needs fewer than a thousand cycles.
   always @(posedge i_clk_sys)
   begin
      if (cycles == 20000)
      begin
         n_fail++;
         complete_run();
      end
   end
   // -------
   // Helpers
   // -------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : cyc
   task automatic wait_obs(input int b, input logic v);
      int n;
      n = 0;
      while (obs[b] !== v && n < 100)
      begin
         cyc(1);
         n++;
      end
   endtask : wait_obs
   task automatic wait_cmd(input int k);
      int n;
      n = 0;
      while (n_cmd < k && n < 60)
      begin
         cyc(1);
         n++;
      end
   endtask : wait_cmd
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   // ---------
   // Scenarios
   // ---------
   task automatic t_basic();
      cyc(1);
      chk("status after reset", o_status_word, 16'h0000);
      i_target_pos <= 32'h0000_0064;
      u_host.setpoint(16'h0000);
      wait_cmd(1);
      chk("target", last_tgt, 32'h0000_0064);
      wait_obs(PPS_SW_ACK, 1'b1);
      chk("ack", obs[PPS_SW_ACK], 1'b1);
      cyc(30);
      chk("starts", n_cmd, 1);
      u_host.put(16'h0000);
      wait_obs(PPS_SW_ACK, 1'b0);
      chk("ack low", obs[PPS_SW_ACK], 1'b0);
      i_demand_pos <= 32'h0000_0064;
      i_actual_pos <= 32'h0000_0064;
      i_ramp_at_target <= 1'b1;
      wait_obs(PPS_SW_REACHED, 1'b1);
      chk("reached", obs[PPS_SW_REACHED], 1'b1);
   endtask : t_basic
   task automatic t_buffer();
      i_ramp_at_target <= 1'b0;
      i_target_pos <= 32'h0000_00c8;
      u_host.setpoint(16'h0000);
      wait_cmd(2);
      i_target_pos <= 32'h0000_012c;
      i_profile_vel <= 32'h0000_0100;
      i_profile_acc <= 32'h0000_0200;
      i_profile_dec <= 32'h0000_0300;
      u_host.setpoint(16'h0200);
      wait_obs(PPS_SW_ACK, 1'b1);
      chk("pass through", o_cmd_pass_through, 1'b1);
      // The buffered entry must keep its own parameters after these change.
      i_profile_vel <= 32'h0000_01f4;
      i_profile_acc <= 32'h0000_01f4;
      i_profile_dec <= 32'h0000_01f4;
      cyc(30);
      chk("queued held", n_cmd, 2);
      u_host.put(16'h0000);
      i_target_pos <= 32'h0000_0190;
      cyc(12);
      u_host.put(16'h0010);
      cyc(30);
      i_ramp_at_target <= 1'b1;
      wait_cmd(3);
      chk("buffered target", last_tgt, 32'h0000_012c);
      chk("buffered vel", o_cmd_vel, 32'h0000_0100);
      chk("buffered acc", o_cmd_acc, 32'h0000_0200);
      chk("buffered dec", o_cmd_dec, 32'h0000_0300);
      cyc(40);
      chk("dropped", n_cmd, 3);
   endtask : t_buffer
   task automatic t_direct();
      i_ramp_at_target <= 1'b0;
      i_target_pos <= 32'h0000_01f4;
      u_host.setpoint(16'h0020);
      wait_cmd(4);
      i_target_pos <= 32'h0000_0258;
      u_host.setpoint(16'h0020);
      wait_cmd(5);
      chk("replaced", last_tgt, 32'h0000_0258);
      i_target_pos <= 32'h0000_0032;
      u_host.setpoint(16'h0060);
      wait_cmd(6);
      chk("relative", last_tgt, 32'h0000_028a);
      i_pos_option <= 8'h12;
      u_host.setpoint(16'h0060);
      wait_cmd(7);
      chk("relative actual", last_tgt, 32'h0000_0096);
      wait_obs(PPS_SW_ACK, 1'b0);
      chk("auto clear", o_ctrl_word[PPS_CW_NEW_SP], 1'b0);
      i_target_pos <= 32'h0000_1388;
      u_host.setpoint(16'h0020);
      wait_cmd(8);
      chk("clamped", last_tgt, 32'h0000_03e8);
      i_demand_pos <= 32'h0000_07d0;
      wait_obs(PPS_SW_LIMIT, 1'b1);
      chk("limit", obs[PPS_SW_LIMIT], 1'b1);
      i_demand_pos <= 32'h0000_03e8;
      wait_obs(PPS_SW_LIMIT, 1'b0);
      chk("limit clear", obs[PPS_SW_LIMIT], 1'b0);
      i_reachable <= 1'b0;
      i_target_pos <= 32'h0000_000a;
      u_host.setpoint(16'h0020);
      cyc(30);
      chk("unreachable", n_cmd, 8);
      chk("no ack", obs[PPS_SW_ACK], 1'b0);
      i_reachable <= 1'b1;
      i_limit_max <= 32'h0000_0032;
      i_target_pos <= 32'h0000_03e8;
      u_host.setpoint(16'h0020);
      cyc(30);
      chk("outward refused", n_cmd, 8);
      i_target_pos <= 32'h0000_000a;
      u_host.setpoint(16'h0020);
      wait_cmd(9);
      chk("inward taken", last_tgt, 32'h0000_000a);
      i_limit_max <= 32'h0000_03e8;
   endtask : t_direct
   task automatic t_halt_ferr_mode();
      u_host.put(16'h0100);
      wait_obs(16, 1'b1);
      chk("halt", obs[16], 1'b1);
      u_host.put(16'h0000);
      wait_obs(16, 1'b0);
      cyc(2);
      chk("release", n_rel, 1);
      i_ramp_speed_ok <= 1'b0;
      u_host.setpoint(16'h0200);
      wait_obs(PPS_SW_ACK, 1'b1);
      chk("pass ignored", o_cmd_pass_through, 1'b0);
      i_closed_loop <= 1'b1;
      i_actual_pos <= 32'h0000_0000;
      wait_obs(PPS_SW_FOLLOW_ERR, 1'b1);
      chk("following error", obs[PPS_SW_FOLLOW_ERR], 1'b1);
      i_closed_loop <= 1'b0;
      i_actual_pos <= 32'h0000_03e8;
      i_operating_mode_select <= 8'h03;
      i_target_pos <= 32'h0000_02bc;
      u_host.setpoint(16'h0020);
      cyc(30);
      chk("other mode", n_cmd, 9);
      chk("mode status", o_status_word & 16'h3c00, 16'h0000);
      i_operating_mode_select <= PPS_MODE_PROFILE_POS;
      wait_cmd(10);
      chk("mode entry", last_tgt, 32'h0000_02bc);
   endtask : t_halt_ferr_mode
   initial
   begin
      repeat (12) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      t_basic();
      t_buffer();
      t_direct();
      t_halt_ferr_mode();
      complete_run();
   end
endmodule : tb
